// ---- bench/rcs_run_command_selector_sva.sv ----
// rcs_run_command_selector_sva: port checks for the run command selector
// assumes binding to rcs_run_command_selector; channel is tracked from apb writes
`timescale 1ns/10ps
`default_nettype none
module rcs_run_command_selector_sva
   import rcs_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // drive command
   input wire logic        runCmd,
   input wire logic        reverseCmd,
   input wire logic        runIndicator
);
   logic [15:0] chanR;
   logic [15:0] chanNxt;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence sDone;
      psel && penable && pready;
   endsequence
   sequence sBadWr(logic [7:0] a, logic [15:0] lim);
      sDone ##0 (pwrite && paddr == a && pwdata[15:0] > lim);
   endsequence
   always_comb
   begin
      chanNxt = chanR;
      if (psel && penable && pready && pwrite && !pslverr && paddr == RCS_OFS_CHANNEL)
      begin
         chanNxt = pwdata[15:0];
      end
   end
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         chanR <= RCS_RST_CHANNEL;
      end
      else
      begin
         chanR <= chanNxt;
      end
   end
   AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
      else $error("pready held two cycles");
   AST_ERR_QUALIFIED: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_INDICATOR: assert property (runIndicator == runCmd)
      else $error("run indicator differs from run command");
   AST_CHANNEL_RANGE: assert property (sBadWr(RCS_OFS_CHANNEL, RCS_MAX_CHANNEL) |-> pslverr)
      else $error("channel above range accepted");
   AST_COMMSRC_RANGE: assert property (sBadWr(RCS_OFS_COMMSRC, RCS_MAX_COMMSRC) |-> pslverr)
      else $error("comm source above range accepted");
   AST_WIRING_RANGE: assert property (sBadWr(RCS_OFS_WIRING, RCS_MAX_WIRING) |-> pslverr)
      else $error("wiring mode above range accepted");
   AST_FUNC_RANGE: assert property (sDone ##0 (pwrite && paddr >= RCS_OFS_IN1FN
      && paddr <= RCS_OFS_FAST2FN && pwdata[15:0] > RCS_MAX_FUNC) |-> pslverr)
      else $error("input function above range accepted");
   AST_UNMAPPED: assert property (sDone ##0 (paddr > RCS_OFS_ID)
      |-> pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   AST_KEYPAD_FORWARD: assert property (chanR == RCS_CH_KEYPAD && $past(chanR) == RCS_CH_KEYPAD
      && $past(chanR, 2) == RCS_CH_KEYPAD |-> !reverseCmd)
      else $error("reverse while keypad channel selected");
endmodule
bind rcs_run_command_selector rcs_run_command_selector_sva u_rcs_run_command_selector_sva
(
   .clock        (clock),
   .reset        (reset),
   .psel         (psel),
   .penable      (penable),
   .pwrite       (pwrite),
   .paddr        (paddr),
   .pwdata       (pwdata),
   .prdata       (prdata),
   .pready       (pready),
   .pslverr      (pslverr),
   .runCmd       (runCmd),
   .reverseCmd   (reverseCmd),
   .runIndicator (runIndicator)
);
`default_nettype wire

// ---- bench/rcs_run_command_selector_tb.sv ----
// rcs_run_command_selector_tb: self-checking bench for the run command selector
// assumes seven comm sources and the terminal model on the input pins
`timescale 1ns/10ps
`default_nettype none
module rcs_run_command_selector_tb
   import rcs_pkg::*;
;
   localparam logic [7:0] OFS [9] = '{RCS_OFS_CHANNEL, RCS_OFS_COMMSRC, RCS_OFS_IN1FN,
      RCS_OFS_IN2FN, RCS_OFS_IN3FN, RCS_OFS_IN4FN, RCS_OFS_FAST1FN, RCS_OFS_FAST2FN,
      RCS_OFS_WIRING};
   localparam logic [15:0] RST [9] = '{RCS_RST_CHANNEL, RCS_RST_COMMSRC, RCS_RST_IN1FN,
      RCS_RST_IN2FN, RCS_RST_IN3FN, RCS_RST_IN4FN, RCS_RST_FASTFN, RCS_RST_FASTFN,
      RCS_RST_WIRING};
   localparam logic [15:0] LIM [9] = '{RCS_MAX_CHANNEL, RCS_MAX_COMMSRC, RCS_MAX_FUNC,
      RCS_MAX_FUNC, RCS_MAX_FUNC, RCS_MAX_FUNC, RCS_MAX_FUNC, RCS_MAX_FUNC, RCS_MAX_WIRING};
   localparam logic [15:0] CFG [6] = '{RCS_FN_FWD, RCS_FN_REV, RCS_FN_ENA3W, RCS_FN_COAST,
      16'h0000, 16'h0000};
   localparam logic [1:0] SEQ2 [6] = '{2'b00, 2'b10, 2'b00, 2'b01, 2'b11, 2'b00};
   // three-wire steps: fwd, rev, enable, expected run, expected reverse
   localparam logic [4:0] STEP3 [2][6] = '{
      '{5'b01101, 5'b11111, 5'b01111, 5'b00110, 5'b01111, 5'b01001},
      '{5'b00101, 5'b10110, 5'b00110, 5'b01111, 5'b00111, 5'b00001}};
   logic        clock = 1'b0, reset = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic        keyRun = 1'b0, keyStop = 1'b0, extStop = 1'b0;
   logic [5:0]  pinReq = 6'h00;
   logic [5:0]  digitalIn;
   logic [6:0]  commValid = 7'h00, commRun = 7'h00, commReverse = 7'h00, commStop = 7'h00;
   logic        runCmd, reverseCmd, jogCmd, coastCmd, runIndicator;
   logic [15:0] v;
   logic [1:0]  exp2 = 2'b00;
   int          numErrors = 0, checked = 0, cycles = 0, k;
   always #5 clock = ~clock;
   rcs_run_command_selector u_rcs_run_command_selector
   (
      .clock        (clock),
      .reset        (reset),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .keyRun       (keyRun),
      .keyStop      (keyStop),
      .digitalIn    (digitalIn),
      .extStop      (extStop),
      .commValid    (commValid),
      .commRun      (commRun),
      .commReverse  (commReverse),
      .commStop     (commStop),
      .runCmd       (runCmd),
      .reverseCmd   (reverseCmd),
      .jogCmd       (jogCmd),
      .coastCmd     (coastCmd),
      .runIndicator (runIndicator)
   );
   rcs_terminal_model u_rcs_terminal_model
   (
      .clock     (clock),
      .pinReq    (pinReq),
      .digitalIn (digitalIn)
   );
   // direction is kept while stopped
   function automatic logic [1:0] twoWire(input logic m, input logic f, input logic r,
                                          input logic p);
      logic run;
      run = m ? f : f ^ r;
      return {run, run ? r : p};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic completeRun;
      $display("mismatches %0d, comparisons %0d", numErrors, checked);
      if (numErrors == 0 && checked > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] expD, input logic expE);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
      begin
         @(posedge clock);
      end
      check(pready, 1'b1);
      check(pslverr, expE);
      if (!w)
      begin
         check(prdata, expD);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic setPins(input logic f, input logic r, input logic e, input logic c);
      @(posedge clock);
      pinReq <= {2'($urandom), c, e, r, f};
      repeat (8) @(posedge clock);
   endtask
   task automatic press(input logic stopKey);
      @(posedge clock);
      keyRun <= !stopKey;
      keyStop <= stopKey;
      repeat (8) @(posedge clock);
      keyRun <= 1'b0;
      keyStop <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
   // c holds stop, reverse, run
   task automatic comm(input int idx, input logic [2:0] c);
      @(posedge clock);
      commValid <= 7'(1 << idx);
      commRun <= {7{c[0]}};
      commReverse <= {7{c[1]}};
      commStop <= {7{c[2]}};
      @(posedge clock);
      commValid <= 7'h00;
      repeat (4) @(posedge clock);
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         numErrors++;
         completeRun;
      end
   end
   initial
   begin
      void'($urandom(32'h11d3600d));
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         apb(OFS[i], 1'b0, 32'h0, {16'h0000, RST[i]}, 1'b0);
      end
      apb(RCS_OFS_ID, 1'b0, 32'h0, RCS_ID_VALUE, 1'b0);
      apb(8'h40, 1'b0, 32'h0, 32'h0, 1'b1);
      apb(RCS_OFS_STATUS, 1'b1, 32'h1, 32'h0, 1'b1);
      for (int i = 0; i < 9; i++)
      begin
         v = 16'($urandom_range(32'(LIM[i])));
         apb(OFS[i], 1'b1, {16'($urandom), v}, 32'h0, 1'b0);
         apb(OFS[i], 1'b1, {16'h0000, LIM[i] + 16'h0001}, 32'h0, 1'b1);
         apb(OFS[i], 1'b0, 32'h0, {16'h0000, v}, 1'b0);
      end
      apb(RCS_OFS_CHANNEL, 1'b1, {16'h0000, RCS_CH_KEYPAD}, 32'h0, 1'b0);
      press(1'b0);
      check({runIndicator, runCmd, reverseCmd}, 3'b110);
      apb(RCS_OFS_STATUS, 1'b0, 32'h0, 32'h1, 1'b0);
      press(1'b1);
      check({runIndicator, runCmd}, 2'b00);
      for (int i = 0; i < 6; i++)
      begin
         apb(OFS[i + 2], 1'b1, {16'h0000, CFG[i]}, 32'h0, 1'b0);
      end
      apb(RCS_OFS_CHANNEL, 1'b1, {16'h0000, RCS_CH_TERMINAL}, 32'h0, 1'b0);
      for (int m = 0; m < 2; m++)
      begin
         apb(RCS_OFS_WIRING, 1'b1, 32'(m), 32'h0, 1'b0);
         for (int i = 0; i < 6; i++)
         begin
            setPins(SEQ2[i][1], SEQ2[i][0], 1'b0, 1'b0);
            exp2 = twoWire(m[0], SEQ2[i][1], SEQ2[i][0], exp2[0]);
            check({runCmd, reverseCmd}, exp2);
         end
      end
      setPins(1'b1, 1'b0, 1'b0, 1'b0);
      extStop <= 1'b1;
      repeat (4) @(posedge clock);
      extStop <= 1'b0;
      repeat (4) @(posedge clock);
      check(runCmd, 1'b0);
      setPins(1'b0, 1'b0, 1'b0, 1'b0);
      setPins(1'b1, 1'b0, 1'b0, 1'b0);
      check(runCmd, 1'b1);
      setPins(1'b1, 1'b0, 1'b0, 1'b1);
      check({runCmd, coastCmd}, 2'b01);
      setPins(1'b0, 1'b0, 1'b0, 1'b0);
      for (int j = 0; j < 2; j++)
      begin
         apb(RCS_OFS_IN4FN, 1'b1, {16'h0000, j ? RCS_FN_JOGR : RCS_FN_JOGF}, 32'h0, 1'b0);
         setPins(1'b0, 1'b0, 1'b0, 1'b1);
         check({jogCmd, reverseCmd}, {1'b1, j[0]});
         setPins(1'b0, 1'b0, 1'b0, 1'b0);
      end
      for (int m = 0; m < 2; m++)
      begin
         apb(RCS_OFS_WIRING, 1'b1, 32'(m + 2), 32'h0, 1'b0);
         for (int i = 0; i < 6; i++)
         begin
            setPins(STEP3[m][i][4], STEP3[m][i][3], STEP3[m][i][2], 1'b0);
            check({runCmd, reverseCmd}, STEP3[m][i][1:0]);
         end
      end
      k = $urandom_range(6);
      apb(RCS_OFS_CHANNEL, 1'b1, {16'h0000, RCS_CH_COMM}, 32'h0, 1'b0);
      apb(RCS_OFS_COMMSRC, 1'b1, 32'(k), 32'h0, 1'b0);
      comm((k + 1) % 7, 3'b011);
      check(runCmd, 1'b0);
      comm(k, 3'b011);
      check({runCmd, reverseCmd}, 2'b11);
      setPins(1'b1, 1'b0, 1'b1, 1'b0);
      check({runCmd, reverseCmd}, 2'b11);
      comm(k, 3'b100);
      check(runCmd, 1'b0);
      completeRun;
   end
endmodule
`default_nettype wire

// ---- bench/rcs_terminal_model.sv ----
// rcs_terminal_model: external switches wired to the input terminals
// assumes the bench sets the wanted contact levels; contacts move after a clock edge
`timescale 1ns/10ps
`default_nettype none
module rcs_terminal_model
(
   // clock
   input  wire logic       clock,
   // wanted contacts and terminals
   input  wire logic [5:0] pinReq,
   output var  logic [5:0] digitalIn = 6'h00
);
   always_ff @(posedge clock)
   begin
      digitalIn <= pinReq;
   end
endmodule
`default_nettype wire

// ---- rtl/rcs_in_sync.sv ----
// rcs_in_sync: three-stage synchroniser with agreement filter for one pin
// assumes an asynchronous pin and the single system clock
`timescale 1ns/10ps
`default_nettype none
module rcs_in_sync
(
   // clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // pin and filtered level
   input  wire logic pinIn,
   output var  logic level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } rcs_sync_s;

   rcs_sync_s state_r;
   rcs_sync_s state_nxt;

   always_comb
   begin
      state_nxt     = state_r;
      state_nxt.s1  = pinIn;
      state_nxt.s2  = state_r.s1;
      state_nxt.s3  = state_r.s2;
      // a change counts once stages two and three agree
      if (state_r.s2 == state_r.s3)
      begin
         state_nxt.lvl = state_r.s3;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign level = state_r.lvl;

endmodule
`default_nettype wire

// ---- rtl/rcs_pkg.sv ----
// rcs_pkg: constants, register map and carrier types for the run command selector
// assumes an APB slave with 32-bit data, one register per aligned word
package rcs_pkg;

   // register byte offsets
   localparam logic [7:0] RCS_OFS_CHANNEL  = 8'h00;
   localparam logic [7:0] RCS_OFS_COMMSRC  = 8'h04;
   localparam logic [7:0] RCS_OFS_IN1FN    = 8'h08;
   localparam logic [7:0] RCS_OFS_IN2FN    = 8'h0C;
   localparam logic [7:0] RCS_OFS_IN3FN    = 8'h10;
   localparam logic [7:0] RCS_OFS_IN4FN    = 8'h14;
   localparam logic [7:0] RCS_OFS_FAST1FN  = 8'h18;
   localparam logic [7:0] RCS_OFS_FAST2FN  = 8'h1C;
   localparam logic [7:0] RCS_OFS_WIRING   = 8'h20;
   localparam logic [7:0] RCS_OFS_STATUS   = 8'h24;
   localparam logic [7:0] RCS_OFS_COMMCMD  = 8'h28;
   localparam logic [7:0] RCS_OFS_ID       = 8'h2C;

   // identification word, value arbitrary
   localparam logic [31:0] RCS_ID_VALUE    = 32'h0000_5A01;

   // reset values
   localparam logic [15:0] RCS_RST_CHANNEL = 16'h0000;
   localparam logic [15:0] RCS_RST_COMMSRC = 16'h0000;
   localparam logic [15:0] RCS_RST_IN1FN   = 16'h0001;
   localparam logic [15:0] RCS_RST_IN2FN   = 16'h0004;
   localparam logic [15:0] RCS_RST_IN3FN   = 16'h0007;
   localparam logic [15:0] RCS_RST_IN4FN   = 16'h0000;
   localparam logic [15:0] RCS_RST_FASTFN  = 16'h0000;
   localparam logic [15:0] RCS_RST_WIRING  = 16'h0000;

   // range limits
   localparam logic [15:0] RCS_MAX_CHANNEL = 16'h0002;
   localparam logic [15:0] RCS_MAX_COMMSRC = 16'h0006;
   localparam logic [15:0] RCS_MAX_FUNC    = 16'h005F;
   localparam logic [15:0] RCS_MAX_WIRING  = 16'h0003;

   // channel codes
   localparam logic [15:0] RCS_CH_KEYPAD   = 16'h0000;
   localparam logic [15:0] RCS_CH_TERMINAL = 16'h0001;
   localparam logic [15:0] RCS_CH_COMM     = 16'h0002;

   // input function codes
   localparam logic [15:0] RCS_FN_FWD      = 16'h0001;
   localparam logic [15:0] RCS_FN_REV      = 16'h0002;
   localparam logic [15:0] RCS_FN_ENA3W    = 16'h0003;
   localparam logic [15:0] RCS_FN_JOGF     = 16'h0004;
   localparam logic [15:0] RCS_FN_JOGR     = 16'h0005;
   localparam logic [15:0] RCS_FN_COAST    = 16'h0006;

   // wiring mode codes
   localparam logic [15:0] RCS_WM_2W1      = 16'h0000;
   localparam logic [15:0] RCS_WM_2W2      = 16'h0001;
   localparam logic [15:0] RCS_WM_3W1      = 16'h0002;
   localparam logic [15:0] RCS_WM_3W2      = 16'h0003;

   // status / comm command bit positions
   localparam int RCS_ST_RUN   = 0;
   localparam int RCS_ST_REV   = 1;
   localparam int RCS_ST_JOG   = 2;
   localparam int RCS_ST_COAST = 3;
   localparam int RCS_CC_RUN   = 0;
   localparam int RCS_CC_REV   = 1;
   localparam int RCS_CC_STOP  = 2;

   // number of input terminals
   localparam int RCS_NUM_IN = 6;

   // command carried to the drive core
   typedef struct packed {
      logic run;
      logic reverse;
      logic jog;
      logic coast;
   } rcs_cmd_s;

   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rcs_apb_req_s;

endpackage

// ---- rtl/rcs_run_command_selector.sv ----
// rcs_run_command_selector: picks run/stop/direction/jog from keypad, terminals or comm
// assumes an APB master on the system clock; keys and terminals are asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module rcs_run_command_selector
   import rcs_pkg::*;
#(
   parameter int NUM_COMM = 7
)
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // keypad keys, asynchronous
   input  wire logic        keyRun,
   input  wire logic        keyStop,
   // digital input terminals, asynchronous: four general then two fast
   input  wire logic [5:0]  digitalIn,
   // external stop from another source
   input  wire logic        extStop,
   // communication commands, one valid strobe per source, same clock
   input  wire logic [NUM_COMM-1:0] commValid,
   input  wire logic [NUM_COMM-1:0] commRun,
   input  wire logic [NUM_COMM-1:0] commReverse,
   input  wire logic [NUM_COMM-1:0] commStop,
   // drive command out
   output var  logic        runCmd,
   output var  logic        reverseCmd,
   output var  logic        jogCmd,
   output var  logic        coastCmd,
   output var  logic        runIndicator
);

   if (NUM_COMM != 32'(RCS_MAX_COMMSRC) + 1)
   begin : g_bad_comm
      $error("NUM_COMM must equal the number of comm sources");
   end

   typedef struct packed {
      logic [15:0] channel;
      logic [15:0] commSrc;
      logic [RCS_NUM_IN-1:0][15:0] inFunc;
      logic [15:0] wiring;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic        fwdPrev;
      logic        revPrev;
      logic        keyRunPrev;
      logic        keyStopPrev;
      logic        latched;
      logic        needRetrig;
      rcs_cmd_s    cmd;
   } rcs_state_s;

   rcs_state_s state_r;
   rcs_state_s state_nxt;

   logic [RCS_NUM_IN-1:0] inLvl;
   logic                  keyRunLvl;
   logic                  keyStopLvl;

   // one filter per pin
   genvar gi;
   generate
      for (gi = 0; gi < RCS_NUM_IN; gi++)
      begin : g_in
         rcs_in_sync u_sync
         (
            .clock (clock),
            .reset (reset),
            .pinIn (digitalIn[gi]),
            .level (inLvl[gi])
         );
      end
   endgenerate

   rcs_in_sync u_key_run
   (
      .clock (clock),
      .reset (reset),
      .pinIn (keyRun),
      .level (keyRunLvl)
   );

   rcs_in_sync u_key_stop
   (
      .clock (clock),
      .reset (reset),
      .pinIn (keyStop),
      .level (keyStopLvl)
   );

   // gather terminal functions: a function is active if any input carrying it is on
   logic fwdIn;
   logic revIn;
   logic enaIn;
   logic jogFIn;
   logic jogRIn;
   logic coastIn;

   always_comb
   begin
      fwdIn   = 1'b0;
      revIn   = 1'b0;
      enaIn   = 1'b0;
      jogFIn  = 1'b0;
      jogRIn  = 1'b0;
      coastIn = 1'b0;
      for (int i = 0; i < RCS_NUM_IN; i++)
      begin
         if (inLvl[i])
         begin
            fwdIn   = fwdIn   | (state_r.inFunc[i] == RCS_FN_FWD);
            revIn   = revIn   | (state_r.inFunc[i] == RCS_FN_REV);
            enaIn   = enaIn   | (state_r.inFunc[i] == RCS_FN_ENA3W);
            jogFIn  = jogFIn  | (state_r.inFunc[i] == RCS_FN_JOGF);
            jogRIn  = jogRIn  | (state_r.inFunc[i] == RCS_FN_JOGR);
            coastIn = coastIn | (state_r.inFunc[i] == RCS_FN_COAST);
         end
      end
   end

   logic       apbAccess;
   logic       wrOk;
   logic [7:0] idx;
   logic       fwdRise;
   logic       revRise;
   logic       revToggle;
   logic       twoWire;
   logic       twoRun;
   logic       twoRev;

   always_comb
   begin
      state_nxt  = state_r;
      apbAccess  = psel && penable;
      idx        = 8'h00;
      wrOk       = 1'b0;
      fwdRise    = fwdIn && !state_r.fwdPrev;
      revRise    = revIn && !state_r.revPrev;
      revToggle  = revIn != state_r.revPrev;
      twoWire    = (state_r.wiring == RCS_WM_2W1) || (state_r.wiring == RCS_WM_2W2);
      twoRun     = 1'b0;
      twoRev     = 1'b0;

      // apb: zero wait states, answer in the access cycle
      state_nxt.ready  = 1'b0;
      state_nxt.slverr = 1'b0;
      // write legality is settled in setup so that the error stands with pready
      unique case (paddr)
         RCS_OFS_CHANNEL: wrOk = pwdata[15:0] <= RCS_MAX_CHANNEL;
         RCS_OFS_COMMSRC: wrOk = pwdata[15:0] <= RCS_MAX_COMMSRC;
         RCS_OFS_IN1FN, RCS_OFS_IN2FN, RCS_OFS_IN3FN, RCS_OFS_IN4FN,
         RCS_OFS_FAST1FN, RCS_OFS_FAST2FN:
            wrOk = pwdata[15:0] <= RCS_MAX_FUNC;
         RCS_OFS_WIRING:  wrOk = pwdata[15:0] <= RCS_MAX_WIRING;
         default:         wrOk = 1'b0;
      endcase
      if (psel && !penable)
      begin
         state_nxt.ready = 1'b1;
         state_nxt.rdata = 32'h0000_0000;
         unique case (paddr)
            RCS_OFS_CHANNEL: state_nxt.rdata = {16'h0000, state_r.channel};
            RCS_OFS_COMMSRC: state_nxt.rdata = {16'h0000, state_r.commSrc};
            RCS_OFS_IN1FN:   state_nxt.rdata = {16'h0000, state_r.inFunc[0]};
            RCS_OFS_IN2FN:   state_nxt.rdata = {16'h0000, state_r.inFunc[1]};
            RCS_OFS_IN3FN:   state_nxt.rdata = {16'h0000, state_r.inFunc[2]};
            RCS_OFS_IN4FN:   state_nxt.rdata = {16'h0000, state_r.inFunc[3]};
            RCS_OFS_FAST1FN: state_nxt.rdata = {16'h0000, state_r.inFunc[4]};
            RCS_OFS_FAST2FN: state_nxt.rdata = {16'h0000, state_r.inFunc[5]};
            RCS_OFS_WIRING:  state_nxt.rdata = {16'h0000, state_r.wiring};
            RCS_OFS_STATUS:
            begin
               state_nxt.rdata[RCS_ST_RUN]   = state_r.cmd.run;
               state_nxt.rdata[RCS_ST_REV]   = state_r.cmd.reverse;
               state_nxt.rdata[RCS_ST_JOG]   = state_r.cmd.jog;
               state_nxt.rdata[RCS_ST_COAST] = state_r.cmd.coast;
            end
            RCS_OFS_COMMCMD: state_nxt.rdata = 32'h0000_0000;
            RCS_OFS_ID:      state_nxt.rdata = RCS_ID_VALUE;
            default:         state_nxt.slverr = 1'b1;
         endcase
         if (pwrite)
         begin
            state_nxt.slverr = !wrOk;
         end
      end
      // a refused write leaves the register as it was
      if (apbAccess && state_r.ready && pwrite && wrOk)
      begin
         unique case (paddr)
            RCS_OFS_CHANNEL: state_nxt.channel = pwdata[15:0];
            RCS_OFS_COMMSRC: state_nxt.commSrc = pwdata[15:0];
            RCS_OFS_IN1FN, RCS_OFS_IN2FN, RCS_OFS_IN3FN, RCS_OFS_IN4FN,
            RCS_OFS_FAST1FN, RCS_OFS_FAST2FN:
            begin
               idx = (paddr - RCS_OFS_IN1FN) >> 2;
               state_nxt.inFunc[idx[2:0]] = pwdata[15:0];
            end
            RCS_OFS_WIRING:  state_nxt.wiring = pwdata[15:0];
            default:         idx = 8'h00;
         endcase
      end

      state_nxt.fwdPrev     = fwdIn;
      state_nxt.revPrev     = revIn;
      state_nxt.keyRunPrev  = keyRunLvl;
      state_nxt.keyStopPrev = keyStopLvl;

      // command engine
      unique case (state_r.channel)
         RCS_CH_KEYPAD:
         begin
            state_nxt.cmd.jog     = 1'b0;
            state_nxt.cmd.coast   = 1'b0;
            state_nxt.cmd.reverse = 1'b0;
            if (keyStopLvl && !state_r.keyStopPrev)
               state_nxt.cmd.run = 1'b0;
            else if (keyRunLvl && !state_r.keyRunPrev)
               state_nxt.cmd.run = 1'b1;
         end
         RCS_CH_TERMINAL:
         begin
            state_nxt.cmd.coast = coastIn;
            state_nxt.cmd.jog   = (jogFIn ^ jogRIn) && !state_r.cmd.run;
            if (twoWire)
            begin
               if (state_r.wiring == RCS_WM_2W1)
               begin
                  twoRun = fwdIn ^ revIn;
                  twoRev = revIn;
               end
               else
               begin
                  twoRun = fwdIn;
                  twoRev = revIn;
               end
               // a stop from elsewhere blocks until the command is released
               if (extStop || coastIn)
                  state_nxt.needRetrig = twoRun;
               else if (!twoRun)
                  state_nxt.needRetrig = 1'b0;
               state_nxt.cmd.run     = twoRun && !state_r.needRetrig && !extStop && !coastIn;
               state_nxt.cmd.reverse = twoRun ? twoRev : state_r.cmd.reverse;
            end
            else
            begin
               state_nxt.needRetrig = 1'b0;
               if (!enaIn || extStop || coastIn)
                  state_nxt.cmd.run = 1'b0;
               else if (state_r.wiring == RCS_WM_3W1)
               begin
                  if (!state_r.cmd.run && fwdRise)
                  begin
                     state_nxt.cmd.run     = 1'b1;
                     state_nxt.cmd.reverse = revIn;
                  end
                  else if (state_r.cmd.run && revToggle)
                     state_nxt.cmd.reverse = !state_r.cmd.reverse;
               end
               else
               begin
                  if (fwdRise)
                  begin
                     state_nxt.cmd.run     = 1'b1;
                     state_nxt.cmd.reverse = 1'b0;
                  end
                  else if (revRise)
                  begin
                     state_nxt.cmd.run     = 1'b1;
                     state_nxt.cmd.reverse = 1'b1;
                  end
               end
            end
            if (state_nxt.cmd.jog)
               state_nxt.cmd.reverse = jogRIn;
         end
         RCS_CH_COMM:
         begin
            state_nxt.cmd.jog   = 1'b0;
            state_nxt.cmd.coast = 1'b0;
            // only the selected source is heard
            if (commValid[state_r.commSrc[2:0]])
            begin
               if (commStop[state_r.commSrc[2:0]])
                  state_nxt.cmd.run = 1'b0;
               else if (commRun[state_r.commSrc[2:0]])
               begin
                  state_nxt.cmd.run     = 1'b1;
                  state_nxt.cmd.reverse = commReverse[state_r.commSrc[2:0]];
               end
            end
         end
         default:
         begin
            state_nxt.cmd = '0;
         end
      endcase

      // leaving a channel always drops the command
      if (state_nxt.channel != state_r.channel)
      begin
         state_nxt.cmd        = '0;
         state_nxt.needRetrig = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_r             <= '0;
         state_r.channel     <= RCS_RST_CHANNEL;
         state_r.commSrc     <= RCS_RST_COMMSRC;
         state_r.inFunc[0]   <= RCS_RST_IN1FN;
         state_r.inFunc[1]   <= RCS_RST_IN2FN;
         state_r.inFunc[2]   <= RCS_RST_IN3FN;
         state_r.inFunc[3]   <= RCS_RST_IN4FN;
         state_r.inFunc[4]   <= RCS_RST_FASTFN;
         state_r.inFunc[5]   <= RCS_RST_FASTFN;
         state_r.wiring      <= RCS_RST_WIRING;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign prdata       = state_r.rdata;
   assign pready       = state_r.ready;
   assign pslverr      = state_r.slverr;
   assign runCmd       = state_r.cmd.run;
   assign reverseCmd   = state_r.cmd.reverse;
   assign jogCmd       = state_r.cmd.jog;
   assign coastCmd     = state_r.cmd.coast;
   assign runIndicator = state_r.cmd.run;

endmodule
`default_nettype wire
